// ==== ced_top.sv ====
// Dual comparator edge control with AXI4-Lite register slave
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module ced_top
    import ced_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid_i,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid_i,
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic s_axi_bvalid_o,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid_i,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic s_axi_rvalid_o,
    output logic [AXI_DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rready_i,
    // Analog comparator outputs
    input wire logic cmp_a_raw_i,
    input wire logic cmp_b_raw_i,
    // Analog stage controls
    output logic cmp_a_on_o,
    output logic cmp_b_on_o,
    output logic [1:0] cmp_a_neg_hyst_sel_o,
    output logic [1:0] cmp_a_pos_hyst_sel_o,
    output logic [1:0] cmp_b_neg_hyst_sel_o,
    output logic [1:0] cmp_b_pos_hyst_sel_o,
    // Interrupts
    output logic cmp_a_irq_o,
    output logic cmp_b_irq_o,
    output logic irq_o
);

    // Maps a byte address to a register select
    function automatic ced_sel_t decode(input logic [AXI_ADDR_W-1:0] addr);
        ced_sel_t sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0)
        begin
            case (addr)
                CTRL_A_OFFSET: sel = SEL_CTRL_A;
                CTRL_B_OFFSET: sel = SEL_CTRL_B;
                STATUS_OFFSET: sel = SEL_STATUS;
                MASK_OFFSET: sel = SEL_MASK;
                default: sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction : decode

    // Bus state
    logic aw_held_reg;
    logic aw_held_next;
    logic [AXI_ADDR_W-1:0] aw_addr_reg;
    logic [AXI_ADDR_W-1:0] aw_addr_next;
    logic w_held_reg;
    logic w_held_next;
    logic [AXI_DATA_W-1:0] w_data_reg;
    logic [AXI_DATA_W-1:0] w_data_next;
    logic w_lane0_reg;
    logic w_lane0_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [AXI_DATA_W-1:0] rdata_reg;
    logic [AXI_DATA_W-1:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic wr_fire;
    logic ar_take;
    ced_sel_t wr_sel;
    ced_sel_t rd_sel;
    logic [AXI_DATA_W-1:0] rd_word;

    // Configuration state
    logic [NUM_CH-1:0][HYST_W-1:0] hyst_reg;
    logic [NUM_CH-1:0][HYST_W-1:0] hyst_next;
    logic [NUM_CH-1:0] on_reg;
    logic [NUM_CH-1:0] on_next;
    logic [ST_W-1:0] mask_reg;
    logic [ST_W-1:0] mask_next;
    logic [NUM_CH-1:0] chan_irq_reg;
    logic [NUM_CH-1:0] chan_irq_next;
    logic irq_reg;
    logic irq_next;

    // Channel signals
    logic [NUM_CH-1:0] raw;
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0] rise_evt;
    logic [NUM_CH-1:0] fall_evt;
    logic [NUM_CH-1:0] rise_flag;
    logic [NUM_CH-1:0] fall_flag;
    logic [NUM_CH-1:0] clr_rise;
    logic [NUM_CH-1:0] clr_fall;
    logic [ST_W-1:0] status;

    assign raw = {cmp_b_raw_i, cmp_a_raw_i};
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign ar_take = s_axi_arvalid_i && arready_reg;
    assign wr_sel = decode(aw_addr_reg);
    assign rd_sel = decode(s_axi_araddr_i);

    // Per channel synchroniser and sticky flags
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_chan
        ced_edge_det u_det (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .raw_i(raw[ch]),
            .level_o(level[ch]),
            .rise_o(rise_evt[ch]),
            .fall_o(fall_evt[ch])
        );
        ced_edge_flags u_flags (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .set_rise_i(rise_evt[ch] && on_reg[ch]),
            .set_fall_i(fall_evt[ch] && on_reg[ch]),
            .clr_rise_i(clr_rise[ch]),
            .clr_fall_i(clr_fall[ch]),
            .rise_flag_o(rise_flag[ch]),
            .fall_flag_o(fall_flag[ch])
        );
        assign status[ch*ST_STRIDE+ST_RISE_BASE] = rise_flag[ch];
        assign status[ch*ST_STRIDE+ST_FALL_BASE] = fall_flag[ch];
    end

    // Write channels: capture address and data in either order
    always_comb
    begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_lane0_next = w_lane0_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (bvalid_reg && s_axi_bready_i)
        begin
            bvalid_next = 1'b0;
        end
        if (wr_fire)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_axi_awvalid_i && awready_reg)
        begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready_reg)
        begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata_i;
            w_lane0_next = s_axi_wstrb_i[0];
        end
        awready_next = !aw_held_next;
        wready_next = !w_held_next;
    end

    // Read data mux; flags and output state show live hardware values
    always_comb
    begin
        rd_word = '0;
        case (rd_sel)
            SEL_CTRL_A, SEL_CTRL_B:
            begin
                rd_word[HYST_W-1:0] = hyst_reg[rd_sel == SEL_CTRL_B]; // RULE1
                rd_word[FALL_BIT] = fall_flag[rd_sel == SEL_CTRL_B];
                rd_word[RISE_BIT] = rise_flag[rd_sel == SEL_CTRL_B];
                rd_word[OUT_BIT] = level[rd_sel == SEL_CTRL_B]; // RULE12
                rd_word[ON_BIT] = on_reg[rd_sel == SEL_CTRL_B];
            end
            SEL_STATUS: rd_word[ST_W-1:0] = status;
            SEL_MASK: rd_word[ST_W-1:0] = mask_reg;
            default: rd_word = '0;
        endcase
    end

    // Read channels: one read at a time
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready_i)
        begin
            rvalid_next = 1'b0;
        end
        if (ar_take)
        begin
            rvalid_next = 1'b1;
            rdata_next = rd_word;
            rresp_next = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        arready_next = !rvalid_next;
    end

    // Register writes and flag clears
    always_comb
    begin
        hyst_next = hyst_reg;
        on_next = on_reg;
        mask_next = mask_reg;
        clr_rise = '0;
        clr_fall = '0;
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            if (wr_fire && w_lane0_reg)
            begin
                if (wr_sel == ((ch == 0) ? SEL_CTRL_A : SEL_CTRL_B))
                begin
                    hyst_next[ch] = w_data_reg[HYST_W-1:0]; // RULE2 RULE3 RULE4 RULE5
                    on_next[ch] = w_data_reg[ON_BIT]; // RULE13
                    clr_rise[ch] = !w_data_reg[RISE_BIT]; // RULE9
                    clr_fall[ch] = !w_data_reg[FALL_BIT]; // RULE9
                end
                if (wr_sel == SEL_STATUS)
                begin
                    clr_rise[ch] = w_data_reg[ch*ST_STRIDE+ST_RISE_BASE];
                    clr_fall[ch] = w_data_reg[ch*ST_STRIDE+ST_FALL_BASE];
                end
            end
        end
        if (wr_fire && w_lane0_reg && wr_sel == SEL_MASK)
        begin
            mask_next = w_data_reg[ST_W-1:0]; // RULE10 RULE11
        end
    end

    // Interrupt requests gated by the mask
    always_comb
    begin
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            chan_irq_next[ch] = |(status[ch*ST_STRIDE +: ST_STRIDE]
                & mask_reg[ch*ST_STRIDE +: ST_STRIDE]); // RULE15
        end
        irq_next = |(status & mask_reg); // RULE10 RULE11
    end

    // Registers
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg <= 1'b0;
            w_data_reg <= '0;
            w_lane0_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            hyst_reg <= {NUM_CH{HYST_RESET}};
            on_reg <= {NUM_CH{ON_RESET}};
            mask_reg <= MASK_RESET;
            chan_irq_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_lane0_reg <= w_lane0_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            hyst_reg <= hyst_next;
            on_reg <= on_next;
            mask_reg <= mask_next;
            chan_irq_reg <= chan_irq_next;
            irq_reg <= irq_next;
        end
    end

    // Outputs from flops
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign cmp_a_on_o = on_reg[0];
    assign cmp_b_on_o = on_reg[1];
    assign cmp_a_neg_hyst_sel_o = hyst_reg[0][HYST_NEG_LSB +: 2];
    assign cmp_a_pos_hyst_sel_o = hyst_reg[0][HYST_POS_LSB +: 2];
    assign cmp_b_neg_hyst_sel_o = hyst_reg[1][HYST_NEG_LSB +: 2];
    assign cmp_b_pos_hyst_sel_o = hyst_reg[1][HYST_POS_LSB +: 2];
    assign cmp_a_irq_o = chan_irq_reg[0];
    assign cmp_b_irq_o = chan_irq_reg[1];
    assign irq_o = irq_reg;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence ar_take_s;
        s_axi_arvalid_i && s_axi_arready_o && (rd_sel == SEL_CTRL_A);
    endsequence
    sequence a_state_shown_s(logic lvl);
        s_axi_rvalid_o && (s_axi_rdata_o[OUT_BIT] == lvl);
    endsequence
    sequence a_ctrl_write_s;
        wr_fire && w_lane0_reg && (wr_sel == SEL_CTRL_A);
    endsequence

    out_state_read_a: assert property ( // RULE12
        ar_take_s |=> a_state_shown_s($past(level[0])))
        else $error("read of control A did not show the output state");
    hyst_forward_a: assert property (a_ctrl_write_s |=> // RULE3
        {cmp_a_pos_hyst_sel_o, cmp_a_neg_hyst_sel_o} == $past(w_data_reg[HYST_W-1:0]))
        else $error("hysteresis field not forwarded to the analog stage");
    chan_on_a: assert property (a_ctrl_write_s |=> cmp_a_on_o == $past(w_data_reg[ON_BIT])) // RULE13
        else $error("channel A enable does not follow the written bit");
    rise_sets_flag_a: assert property (rise_evt[1] && on_reg[1] |=> rise_flag[1]) // RULE8
        else $error("channel B rising edge did not set its flag");
    fall_sets_flag_a: assert property (fall_evt[0] && on_reg[0] |=> fall_flag[0]) // RULE7
        else $error("channel A falling edge did not set its flag");
    flag_no_self_clear_a: assert property (rise_flag[0] && !clr_rise[0] |=> rise_flag[0]) // RULE9
        else $error("channel A rise flag cleared without software");
    zero_write_clears_a: assert property ( // RULE9
        a_ctrl_write_s and (!w_data_reg[FALL_BIT] && !fall_evt[0]) |=> !fall_flag[0])
        else $error("writing zero did not clear the channel A fall flag");
    chan_irq_level_a: assert property ( // RULE15
        (rise_flag[1] && mask_reg[2]) ##1 (rise_flag[1] && mask_reg[2]) |-> cmp_b_irq_o)
        else $error("channel B interrupt low while masked-in flag set");
    irq_masked_off_a: assert property ((mask_reg == '0) [*2] |-> !irq_o) // RULE10 RULE11
        else $error("interrupt raised with every mask bit zero");
    write_answer_a: assert property (wr_fire |=> s_axi_bvalid_o ##0
        (s_axi_bresp_o == ($past(wr_sel) == SEL_NONE ? RESP_SLVERR : RESP_OKAY)))
        else $error("write response missing or wrong");
    bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before it was taken");

endmodule : ced_top

`default_nettype wire

// ==== ced_pkg.sv ====
// Constants and types for the dual comparator edge control block
// What this block does
// [RULE1] Two independent comparator channels each have their own control register.
// [RULE2] Software sets the amount and symmetry of hysteresis for each channel.
// [RULE3] Hysteresis settings sit in control bits 3 to 0 and drive the analog stage.
// [RULE4] The negative hysteresis field selects off, 5 mV, 10 mV or 20 mV.
// [RULE5] A separate positive hysteresis field offers the same choices per channel.
// [RULE6] Events are raised on both rising and falling comparator output transitions.
// [RULE7] A falling transition sets that channel's falling edge flag to one.
// [RULE8] A rising transition sets that channel's rising edge flag to one.
// [RULE9] Edge flags stay set until software clears them; hardware never clears them.
// [RULE10] A one in a channel's rising mask bit enables its rising edge interrupt.
// [RULE11] A one in a channel's falling mask bit enables its falling edge interrupt.
// [RULE12] A read-only bit per channel shows the current comparator output state.
// [RULE13] A channel is on while its enable bit is one and off while it is zero.
// [RULE14] Software should clear both edge flags shortly after enabling or reconfiguring.
// [RULE15] A channel's interrupt is high while any flag is set with its mask bit set.
`default_nettype none

package ced_pkg;

    // Bus geometry
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int NUM_CH = 2;

    // Register byte offsets
    localparam logic [7:0] CTRL_A_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_B_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] MASK_OFFSET = 8'h0c;

    // Control register field positions
    localparam int HYST_NEG_LSB = 0;
    localparam int HYST_POS_LSB = 2;
    localparam int HYST_W = 4;
    localparam int FALL_BIT = 4;
    localparam int RISE_BIT = 5;
    localparam int OUT_BIT = 6;
    localparam int ON_BIT = 7;

    // Status and mask layout: channel n uses bits 2n (rise) and 2n+1 (fall)
    localparam int ST_RISE_BASE = 0;
    localparam int ST_FALL_BASE = 1;
    localparam int ST_STRIDE = 2;
    localparam int ST_W = 4;

    // Values after reset
    localparam logic [3:0] HYST_RESET = 4'h0;
    localparam logic ON_RESET = 1'b0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Hysteresis choices for either field
    typedef enum logic [1:0] {
        HYST_OFF = 2'b00,
        HYST_5MV = 2'b01,
        HYST_10MV = 2'b10,
        HYST_20MV = 2'b11
    } ced_hyst_t;

    // Register select codes from address decode
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_CTRL_A = 3'b001,
        SEL_CTRL_B = 3'b010,
        SEL_STATUS = 3'b011,
        SEL_MASK = 3'b100
    } ced_sel_t;

endpackage : ced_pkg

`default_nettype wire

// ==== ced_edge_det.sv ====
// Input synchroniser, glitch filter and edge detector for one comparator output
`timescale 1ns/10ps
`default_nettype none

module ced_edge_det
    import ced_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Raw comparator output from the analog stage
    input wire logic raw_i,
    // Filtered level and edge pulses
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic level_reg;
    logic level_next;
    logic rise_reg;
    logic rise_next;
    logic fall_reg;
    logic fall_next;
    logic agree;

    // Stage one feeds only stage two; stages two and three must agree
    always_comb
    begin
        sync_next = {sync_reg[1:0], raw_i};
        agree = (sync_reg[1] == sync_reg[2]);
        level_next = agree ? sync_reg[2] : level_reg;
        rise_next = agree && sync_reg[2] && !level_reg; // RULE6
        fall_next = agree && !sync_reg[2] && level_reg; // RULE6
    end

    // Registers
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            sync_reg <= SYNC_RESET;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end
        else
        begin
            sync_reg <= sync_next;
            level_reg <= level_next;
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign level_o = level_reg;
    assign rise_o = rise_reg;
    assign fall_o = fall_reg;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    rise_marks_level_a: assert property (rise_o |-> level_o && !$past(level_o)) // RULE6
        else $error("rise pulse without a low to high level change");
    fall_marks_level_a: assert property (fall_o |-> !level_o && $past(level_o)) // RULE6
        else $error("fall pulse without a high to low level change");

endmodule : ced_edge_det

`default_nettype wire

// ==== ced_edge_flags.sv ====
// Sticky rising and falling edge flags of one comparator channel
`timescale 1ns/10ps
`default_nettype none

module ced_edge_flags
    import ced_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Set and clear requests
    input wire logic set_rise_i,
    input wire logic set_fall_i,
    input wire logic clr_rise_i,
    input wire logic clr_fall_i,
    // Flag state
    output logic rise_flag_o,
    output logic fall_flag_o
);

    logic rise_reg;
    logic rise_next;
    logic fall_reg;
    logic fall_next;

    // A set in the clearing cycle wins
    always_comb
    begin
        rise_next = set_rise_i || (rise_reg && !clr_rise_i); // RULE8 RULE9
        fall_next = set_fall_i || (fall_reg && !clr_fall_i); // RULE7 RULE9
    end

    // Registers
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end
        else
        begin
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign rise_flag_o = rise_reg;
    assign fall_flag_o = fall_reg;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    set_beats_clear_a: assert property (set_rise_i && clr_rise_i |=> rise_flag_o) // RULE9
        else $error("rise flag lost an event that met a clear");
    fall_sticky_a: assert property (fall_flag_o && !clr_fall_i |=> fall_flag_o) // RULE9
        else $error("fall flag dropped without a clear");

endmodule : ced_edge_flags

`default_nettype wire

// ==== ced_analog_model.sv ====
// Behavioural analog comparator stage for one channel
`timescale 1ns/10ps
`default_nettype none

module ced_analog_model
    import ced_pkg::*;
(
    // Controls from the block
    input wire logic on_i,
    input wire logic [1:0] neg_hyst_i,
    input wire logic [1:0] pos_hyst_i,
    // Input level set by the bench
    input wire logic level_i,
    // Comparator decision
    output logic raw_o
);
    // A switched-off stage holds its output low
    assign raw_o = on_i ? level_i : 1'b0;
endmodule : ced_analog_model

`default_nettype wire

// ==== tb_ced_top.sv ====
// Register level testbench for the dual comparator edge block
`timescale 1ns/10ps
`default_nettype none

module tb_ced_top
    import ced_pkg::*;
;

    logic clk, rst, awv, awr, wv, wr_o, bv, br, arv, arr, rv, rr;
    logic [7:0] aw, ar;
    logic [3:0] ws;
    logic [31:0] wd, rd_o;
    logic [1:0] bresp, rresp, an, ap, bn, bp;
    logic a_on, b_on, ra, rb, lvl_a, lvl_b, irq_a, irq_b, irq;
    int bad_count, comparisons;

    ced_top i_dut (.clock_i(clk), .rst_i(rst), .s_axi_awvalid_i(awv),
        .s_axi_awaddr_i(aw), .s_axi_awready_o(awr), .s_axi_wvalid_i(wv),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wready_o(wr_o),
        .s_axi_bvalid_o(bv), .s_axi_bresp_o(bresp), .s_axi_bready_i(br),
        .s_axi_arvalid_i(arv), .s_axi_araddr_i(ar), .s_axi_arready_o(arr),
        .s_axi_rvalid_o(rv), .s_axi_rdata_o(rd_o), .s_axi_rresp_o(rresp),
        .s_axi_rready_i(rr), .cmp_a_raw_i(ra), .cmp_b_raw_i(rb),
        .cmp_a_on_o(a_on), .cmp_b_on_o(b_on), .cmp_a_neg_hyst_sel_o(an),
        .cmp_a_pos_hyst_sel_o(ap), .cmp_b_neg_hyst_sel_o(bn),
        .cmp_b_pos_hyst_sel_o(bp), .cmp_a_irq_o(irq_a), .cmp_b_irq_o(irq_b),
        .irq_o(irq));

    // Analog stages of both channels
    ced_analog_model i_ana_a (.on_i(a_on), .neg_hyst_i(an), .pos_hyst_i(ap),
        .level_i(lvl_a), .raw_o(ra));
    ced_analog_model i_ana_b (.on_i(b_on), .neg_hyst_i(bn), .pos_hyst_i(bp),
        .level_i(lvl_b), .raw_o(rb));

    // Verdict and end of run
    task tally_and_finish;
        $display("Checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // Compare seen against expected
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // A spent wait bound ends the run
    task to_chk(input int n);
        if (n >= 40)
        begin
            bad_count++;
            tally_and_finish;
        end
    endtask : to_chk

    // AXI4-Lite write with expected response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awv <= 1'b1;
        wv <= 1'b1;
        aw <= a;
        wd <= d;
        br <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_o) wv <= 1'b0;
            n++;
        end
        while (bv !== 1'b1 && n < 40);
        br <= 1'b0;
        to_chk(n);
        chk("bresp", bresp, er);
    endtask : wr

    // AXI4-Lite read compared with expected data and response
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        arv <= 1'b1;
        ar <= a;
        rr <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            n++;
        end
        while (rv !== 1'b1 && n < 40);
        rr <= 1'b0;
        to_chk(n);
        chk("rdata", rd_o, e);
        chk("rresp", rresp, er);
    endtask : rc

    // Clock at 40 MHz
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Main sequence
    initial
    begin
        {rst, awv, wv, br, arv, rr, lvl_a, lvl_b} = 8'h80;
        {aw, ar, wd, ws} = 52'hf;
        bad_count = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rc(CTRL_A_OFFSET, 32'h0, RESP_OKAY);
        rc(MASK_OFFSET, 32'h0, RESP_OKAY);
        for (int k = 0; k < 4; k++)
        begin
            wr(CTRL_B_OFFSET, {24'h0, 4'h8, 2'(k), 2'(3 - k)}, RESP_OKAY);
            chk("b_pos", bp, 32'(k));
            chk("b_neg", bn, 32'(3 - k));
            chk("b_on", b_on, 32'h1);
        end
        wr(CTRL_B_OFFSET, 32'h80, RESP_OKAY);
        wr(CTRL_A_OFFSET, 32'h8d, RESP_OKAY);
        chk("a_hyst", {ap, an}, 32'hd);
        chk("a_on", a_on, 32'h1);
        repeat (10) @(posedge clk);
        wr(STATUS_OFFSET, 32'hf, RESP_OKAY);
        wr(MASK_OFFSET, 32'h2, RESP_OKAY);
        lvl_a <= 1'b1;
        repeat (10) @(posedge clk);
        rc(CTRL_A_OFFSET, 32'hed, RESP_OKAY);
        chk("irq_a", irq_a, 32'h0);
        wr(MASK_OFFSET, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("irq_a", irq_a, 32'h1);
        chk("irq", {irq_b, irq}, 32'h1);
        lvl_a <= 1'b0;
        repeat (10) @(posedge clk);
        rc(STATUS_OFFSET, 32'h3, RESP_OKAY);
        wr(CTRL_A_OFFSET, 32'h9d, RESP_OKAY);
        rc(STATUS_OFFSET, 32'h2, RESP_OKAY);
        chk("irq_a", irq_a, 32'h0);
        wr(MASK_OFFSET, 32'h2, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("irq_a", irq_a, 32'h1);
        wr(STATUS_OFFSET, 32'h2, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("irq", irq, 32'h0);
        lvl_b <= 1'b1;
        repeat (10) @(posedge clk);
        lvl_b <= 1'b0;
        repeat (10) @(posedge clk);
        rc(STATUS_OFFSET, 32'hc, RESP_OKAY);
        wr(MASK_OFFSET, 32'h8, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("irq_ab", {irq_a, irq_b, irq}, 32'h3);
        wr(STATUS_OFFSET, 32'hc, RESP_OKAY);
        wr(CTRL_A_OFFSET, 32'h0, RESP_OKAY);
        lvl_a <= 1'b1;
        repeat (10) @(posedge clk);
        rc(STATUS_OFFSET, 32'h0, RESP_OKAY);
        rc(CTRL_A_OFFSET, 32'h0, RESP_OKAY);
        // Enabling with the input high flags a spurious rise that software clears
        wr(CTRL_A_OFFSET, 32'h80, RESP_OKAY);
        repeat (10) @(posedge clk);
        rc(STATUS_OFFSET, 32'h1, RESP_OKAY);
        // The fall seen after disabling must be discarded
        wr(CTRL_A_OFFSET, 32'h0, RESP_OKAY);
        repeat (10) @(posedge clk);
        rc(STATUS_OFFSET, 32'h0, RESP_OKAY);
        chk("a_on", a_on, 32'h0);
        // A write without byte lane 0 stores nothing
        ws <= 4'h0;
        wr(CTRL_A_OFFSET, 32'h8f, RESP_OKAY);
        ws <= 4'hf;
        rc(CTRL_A_OFFSET, 32'h0, RESP_OKAY);
        wr(8'h10, 32'hff, RESP_SLVERR);
        rc(8'h10, 32'h0, RESP_SLVERR);
        tally_and_finish;
    end
endmodule : tb_ced_top

`default_nettype wire
